// ==== mpgpio_consts.vh ====
// File addresses, field positions, reset values and variant codes of the general-purpose I/O block
`ifndef MPGPIO_CONSTS_VH
`define MPGPIO_CONSTS_VH
`define MPGPIO_ADDR_PORT_A   5'h05
`define MPGPIO_ADDR_PORT_B   5'h06
`define MPGPIO_ADDR_PORT_C   5'h07
`define MPGPIO_ADDR_PORT_D   5'h08
`define MPGPIO_ADDR_PORT_E   5'h09
`define MPGPIO_DIR_RESET     8'hff
`define MPGPIO_PORT_A_MASK   8'h0f
`define MPGPIO_PORT_E_MASK   8'hf0
`define MPGPIO_FULL_MASK     8'hff
`define MPGPIO_VARIANT_SMALL 2'h0
`define MPGPIO_VARIANT_MID   2'h1
`define MPGPIO_VARIANT_LARGE 2'h2
`endif

// ==== mpgpio_multi_port.v ====
// General-purpose I/O block with five ports, pin-level reads and write-only direction registers
// Contract
// - Port reads return pin levels, not latches
// - Reset sets every direction bit to one
// - First port: bits 3..0 only, upper read zero
// - Second port: eight bidirectional pin bits
// - Third port, or plain register on smallest
// - Fourth port only on largest variant
// - Fifth port bits 7..4, else plain register
// - Direction loaded only by direction-load instruction
// - Direction one tristates, zero drives latch
// - Direction registers cannot be read back
// - Output latch holds until next port write
// - Each pin has its own direction bit
// - Latches undefined at power-on, kept otherwise
// - Write at cycle end, read samples at start
`timescale 1ns/1ps
`default_nettype none
`include "mpgpio_consts.vh"

module mpgpio_multi_port #(
    parameter [1:0] VARIANT = `MPGPIO_VARIANT_LARGE
) (
    input  wire        mclk,
    input  wire        reset,
    input  wire        powerOnReset,
    input  wire [4:0]  fileAddr,
    input  wire        fileWrite,
    input  wire        fileRead,
    input  wire [7:0]  fileWrData,
    output reg  [7:0]  fileRdData,
    output wire        fileHit,
    input  wire        dirLoad,
    input  wire [7:0]  accumulator,
    input  wire [7:0]  portAPinIn,
    output wire [7:0]  portAPinOut,
    output wire [7:0]  portAPinOe,
    input  wire [7:0]  portBPinIn,
    output wire [7:0]  portBPinOut,
    output wire [7:0]  portBPinOe,
    input  wire [7:0]  portCPinIn,
    output wire [7:0]  portCPinOut,
    output wire [7:0]  portCPinOe,
    input  wire [7:0]  portDPinIn,
    output wire [7:0]  portDPinOut,
    output wire [7:0]  portDPinOe,
    input  wire [7:0]  portEPinIn,
    output wire [7:0]  portEPinOut,
    output wire [7:0]  portEPinOe
);

    // Port index 0..4 for addresses 05h..09h, 7 for none
    function [2:0] portIndex;
        input [4:0] addr;
        begin
            case (addr)
                `MPGPIO_ADDR_PORT_A: portIndex = 3'h0;
                `MPGPIO_ADDR_PORT_B: portIndex = 3'h1;
                `MPGPIO_ADDR_PORT_C: portIndex = 3'h2;
                `MPGPIO_ADDR_PORT_D: portIndex = 3'h3;
                `MPGPIO_ADDR_PORT_E: portIndex = 3'h4;
                default:             portIndex = 3'h7;
            endcase
        end
    endfunction

    // Pin mask of each port for this variant; zero means plain data register
    function [7:0] pinMask;
        input [2:0] idx;
        begin
            case (idx)
                3'h0: pinMask = `MPGPIO_PORT_A_MASK;
                3'h1: pinMask = `MPGPIO_FULL_MASK;
                3'h2: pinMask = (VARIANT != `MPGPIO_VARIANT_SMALL) ? `MPGPIO_FULL_MASK : 8'h00;
                3'h3: pinMask = (VARIANT == `MPGPIO_VARIANT_LARGE) ? `MPGPIO_FULL_MASK : 8'h00;
                3'h4: pinMask = (VARIANT == `MPGPIO_VARIANT_LARGE) ? `MPGPIO_PORT_E_MASK : 8'h00;
                default: pinMask = 8'h00;
            endcase
        end
    endfunction

    wire [2:0]  accIdx = portIndex(fileAddr);
    wire [39:0] pinInBus = {portEPinIn, portDPinIn, portCPinIn, portBPinIn, portAPinIn};
    wire [39:0] pinOutBus;
    wire [39:0] pinOeBus;
    wire [39:0] syncBus;

    assign fileHit = (accIdx != 3'h7);

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1)
        begin : gPort
            localparam [7:0] MASK = pinMask(g);
            reg  [7:0] latch_q;
            reg  [7:0] dir_q;
            reg  [7:0] s1_q;
            reg  [7:0] s2_q;
            reg  [7:0] s3_q;
            reg  [7:0] level_q;
            wire       sel = (accIdx == g);

            // Latch has no reset term: power-on contents are undefined and other resets keep them
            always @(posedge mclk)
            begin
                if (fileWrite && sel)
                    latch_q <= fileWrData;
            end

            // Direction, synchroniser and read data all take reset; the latch above deliberately escapes it
            always @(posedge mclk or posedge reset)
            begin
                if (reset)
                    dir_q <= `MPGPIO_DIR_RESET;
                else if (dirLoad && sel && MASK != 8'h00)
                    dir_q <= accumulator;
            end

            // Three-stage synchroniser; a level is accepted once stages two and three agree
            always @(posedge mclk or posedge reset)
            begin
                if (reset)
                begin
                    s1_q    <= 8'h00;
                    s2_q    <= 8'h00;
                    s3_q    <= 8'h00;
                    level_q <= 8'h00;
                end
                else
                begin
                    s1_q    <= pinInBus[8*g +: 8];
                    s2_q    <= s1_q;
                    s3_q    <= s2_q;
                    level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
                end
            end

            assign pinOutBus[8*g +: 8] = latch_q & MASK;
            assign pinOeBus[8*g +: 8]  = ~dir_q & MASK;
            // Implemented pins read the pin level; a plain register reads its stored value
            assign syncBus[8*g +: 8]   = (MASK != 8'h00) ? (level_q & MASK) : latch_q;
        end
    endgenerate

    assign portAPinOut = pinOutBus[7:0];
    assign portAPinOe  = pinOeBus[7:0];
    assign portBPinOut = pinOutBus[15:8];
    assign portBPinOe  = pinOeBus[15:8];
    assign portCPinOut = pinOutBus[23:16];
    assign portCPinOe  = pinOeBus[23:16];
    assign portDPinOut = pinOutBus[31:24];
    assign portDPinOe  = pinOeBus[31:24];
    assign portEPinOut = pinOutBus[39:32];
    assign portEPinOe  = pinOeBus[39:32];

    // Read data is registered at the read edge, i.e. sampled at the start of the instruction
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
            fileRdData <= 8'h00;
        else if (fileRead)
        begin
            case (accIdx)
                3'h0:    fileRdData <= syncBus[7:0];
                3'h1:    fileRdData <= syncBus[15:8];
                3'h2:    fileRdData <= syncBus[23:16];
                3'h3:    fileRdData <= syncBus[31:24];
                3'h4:    fileRdData <= syncBus[39:32];
                default: fileRdData <= 8'h00;
            endcase
        end
    end

    // powerOnReset only distinguishes reset kinds outside; latches ignore every reset
    wire unusedPor = powerOnReset;

endmodule // mpgpio_multi_port
`default_nettype wire

// ==== mpgpio_checker.sv ====
// Port-level assertions for the multi-port I/O block
`timescale 1ns/1ps
`default_nettype none
module mpgpio_checker (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic [4:0] fileAddr,
    input wire logic       fileWrite,
    input wire logic [7:0] fileWrData,
    input wire logic       fileRead,
    input wire logic [7:0] fileRdData,
    input wire logic       dirLoad,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] portBPinOut,
    input wire logic [7:0] portBPinOe,
    input wire logic [7:0] portAPinOe,
    input wire logic [7:0] portEPinOe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_oe_reset_off: assert property ($fell(reset) |-> (portAPinOe | portBPinOe | portEPinOe) == 8'h00)
        else $error("drivers on after reset");
    a_dir_load_b: assert property (dirLoad && fileAddr == 5'h06 |=> portBPinOe == ~$past(accumulator))
        else $error("direction load wrong");
    a_dir_hold_b: assert property (!(dirLoad && fileAddr == 5'h06) |=> $stable(portBPinOe))
        else $error("direction changed");
    a_out_write_b: assert property (fileWrite && fileAddr == 5'h06 |=> portBPinOut == $past(fileWrData))
        else $error("latch write wrong");
    a_out_hold_b: assert property (dirLoad && !fileWrite |=> $stable(portBPinOut))
        else $error("latch moved");
    a_read_a_upper: assert property (fileRead && fileAddr == 5'h05 |=> fileRdData[7:4] == 4'h0)
        else $error("upper bits not zero");
    a_rd_hold: assert property (!fileRead |=> $stable(fileRdData))
        else $error("read data moved");
    a_unimpl_oe: assert property ((portAPinOe[7:4] | portEPinOe[3:0]) == 4'h0)
        else $error("missing pin driven");
endmodule // mpgpio_checker
bind mpgpio_multi_port mpgpio_checker u_chk (.mclk, .reset, .fileAddr, .fileWrite, .fileWrData, .fileRead,
    .fileRdData, .dirLoad, .accumulator, .portBPinOut, .portBPinOe, .portAPinOe, .portEPinOe);
`default_nettype wire

// ==== mpgpio_pin_model.sv ====
// Outside circuitry on the second port
`timescale 1ns/1ps
`default_nettype none
module mpgpio_pin_model (
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOe,
    input  wire logic [7:0] extLevel,
    output logic [7:0]      pinLevel
);
    // Released bits take the outside level; driven bits take the output latch
    assign pinLevel = (pinOut & pinOe) | (extLevel & ~pinOe);
endmodule // mpgpio_pin_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the multi-port I/O block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 0, reset = 1, fileWrite = 0, fileRead = 0, dirLoad = 0, fileHit;
    logic [4:0] fileAddr = 0;
    logic [7:0] fileWrData = 0, accumulator = 0, ext = 8'hff, fileRdData, portBPinIn, portBPinOut, portBPinOe;
    int error_cnt = 0, compares = 0, cyc = 0;
    logic [20:0] rows [6] = '{{5'h05, 8'ha5, 8'h05}, {5'h06, 8'h3c, 8'h3c}, {5'h07, 8'h96, 8'h96},
        {5'h08, 8'h69, 8'h69}, {5'h09, 8'ha5, 8'ha0}, {5'h0a, 8'hff, 8'h00}};
    mpgpio_multi_port u_mpgpio_multi_port (.mclk, .reset, .powerOnReset(1'b0), .fileAddr, .fileWrite,
        .fileRead, .fileWrData, .fileRdData, .fileHit, .dirLoad, .accumulator,
        .portAPinIn(ext), .portAPinOut(), .portAPinOe(), .portBPinIn, .portBPinOut, .portBPinOe,
        .portCPinIn(ext), .portCPinOut(), .portCPinOe(), .portDPinIn(ext), .portDPinOut(), .portDPinOe(),
        .portEPinIn(ext), .portEPinOut(), .portEPinOe());
    mpgpio_pin_model u_mpgpio_pin_model (.pinOut(portBPinOut), .pinOe(portBPinOe), .extLevel(ext),
        .pinLevel(portBPinIn));
    always #2.5 mclk = ~mclk;
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Kind 0 read, 1 write, 2 direction load; pins get time to pass the input filter first
    task op(input logic [4:0] a, input logic [1:0] k, input logic [7:0] v);
        repeat (5) @(posedge mclk);
        #1;
        fileAddr = a;
        {fileRead, fileWrite, dirLoad} = {k == 2'h0, k == 2'h1, k == 2'h2};
        fileWrData = v;
        accumulator = v;
        @(posedge mclk);
        #1;
        {fileRead, fileWrite, dirLoad} = 3'h0;
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            error_cnt++;
            conclude();
        end
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        #1 reset = 0;
        chk("oe after reset", portBPinOe, 8'h00);
        foreach (rows[i])
        begin
            ext = rows[i][15:8];
            op(rows[i][20:16], 2'h0, 8'h00);
            chk("port read", fileRdData, rows[i][7:0]);
            chk("file hit", {7'h00, fileHit}, {7'h00, rows[i][20:16] != 5'h0a});
        end
        $display("read table done");
        op(5'h06, 2'h1, 8'h55);
        op(5'h06, 2'h2, 8'h0f);
        op(5'h0a, 2'h2, 8'h00);
        op(5'h06, 2'h0, 8'h00);
        chk("direction", portBPinOe, 8'hf0);
        chk("mixed pins", fileRdData, 8'h5f);
        reset = 1;
        @(posedge mclk);
        #1 reset = 0;
        chk("oe mid reset", portBPinOe, 8'h00);
        chk("latch kept", portBPinOut, 8'h55);
        $display("direction test done");
        conclude();
    end
endmodule // tb
`default_nettype wire
